// ===== shared/pudc_defs.svh
// Constants of the presettable up/down binary counter
//
// Contract
// - Four count bits share one clock and change together, never rippling.
// - Count advances on a rising count-clock edge only while count enable is low.
// - Direction low counts up, high counts down, sampled at the edge.
// - Enable or direction changes between edges never alter the stored count.
// - While load is low each count bit follows its preset input.
// - Terminal flag is high at 15 counting up or 0 counting down.
// - Ripple output is low on terminal count only while count clock is low.
// - Counting up wraps from 15 to 0, then continues 1, 2 and onward.
// - Counting down wraps from 0 to 15, then continues 14, 13 and onward.
`ifndef PUDC_DEFS_SVH
`define PUDC_DEFS_SVH

`define PUDC_WIDTH        4
`define PUDC_COUNT_MAX    4'hF
`define PUDC_COUNT_MIN    4'h0
`define PUDC_COUNT_RST    4'h0
`define PUDC_STEP         4'h1
`define PUDC_PIN_WIDTH    8
`define PUDC_PIN_RST      8'h50
`define PUDC_SYNC_STAGES  2
`define PUDC_CLK_PERIOD_NS 4

`endif

// ===== shared/pudc_pkg.sv
// Types of the presettable up/down binary counter
`include "pudc_defs.svh"
package pudc_pkg;

	// Count value
	typedef logic [`PUDC_WIDTH-1:0] pudc_count_t;

	// Count direction as seen on the direction pin
	typedef enum logic {
		PUDC_DIR_UP   = 1'b0,
		PUDC_DIR_DOWN = 1'b1
	} pudc_dir_e;

	// Pin group, packed in the order used by the synchroniser
	typedef struct packed {
		logic        countClk;
		logic        countEnableLow;
		logic        directionSelect;
		logic        loadN;
		pudc_count_t presetData;
	} pudc_pins_s;

endpackage

// ===== shared/pudc_pin_if.sv
// Pin group between the counter core and its input synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "pudc_defs.svh"
interface pudc_pin_if;
	logic [`PUDC_PIN_WIDTH-1:0] rawPins;
	logic [`PUDC_PIN_WIDTH-1:0] syncPins;

	// Core hands raw pins over and takes synchronised ones back
	modport drv (output rawPins, input syncPins);
	// Synchroniser side
	modport syn (input rawPins, output syncPins);
endinterface
`default_nettype wire

// ===== rtl/pudc_pin_sync.sv
// Two-flop synchroniser for the counter's asynchronous input pins
`timescale 1ns/100ps
`default_nettype none
`include "pudc_defs.svh"
module pudc_pin_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pin group
	pudc_pin_if.syn   pins
);
	import pudc_pkg::*;

	localparam logic [`PUDC_PIN_WIDTH-1:0] PIN_RST = `PUDC_PIN_RST;

	logic [`PUDC_PIN_WIDTH-1:0] stage1_r;
	logic [`PUDC_PIN_WIDTH-1:0] stage2_r;

	// One two-flop chain per pin; first flop feeds only the second
	for (genvar i = 0; i < `PUDC_PIN_WIDTH; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				stage1_r[i] <= PIN_RST[i];
				stage2_r[i] <= PIN_RST[i];
			end else begin
				stage1_r[i] <= pins.rawPins[i];
				stage2_r[i] <= stage1_r[i];
			end
		end
	end

	assign pins.syncPins = stage2_r;

endmodule // pudc_pin_sync
`default_nettype wire

// ===== rtl/pudc_counter.sv
// Presettable 4-bit up/down binary counter with cascade outputs
`timescale 1ns/100ps
`default_nettype none
`include "pudc_defs.svh"
module pudc_counter (
	// System clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Counter pins, asynchronous to clk
	input  wire logic                countClk,
	input  wire logic                countEnableLow,
	input  wire logic                directionSelect,
	input  wire logic                loadN,
	input  wire pudc_pkg::pudc_count_t presetData,
	// Count and cascade outputs
	output var  pudc_pkg::pudc_count_t countValue,
	output var  logic                terminalCountFlag,
	output var  logic                rippleClockOutN
);
	import pudc_pkg::*;

	localparam pudc_count_t COUNT_MAX = `PUDC_COUNT_MAX;
	localparam pudc_count_t COUNT_MIN = `PUDC_COUNT_MIN;
	localparam pudc_count_t COUNT_RST = `PUDC_COUNT_RST;
	localparam pudc_count_t STEP      = `PUDC_STEP;

	pudc_pin_if pinBus ();
	pudc_pins_s rawS;
	pudc_pins_s syncS;

	pudc_count_t count_r;
	pudc_count_t count_nxt;
	logic        clkPrev_r;
	logic        countEdge;
	logic        termFlag_r;
	logic        termFlag_nxt;
	logic        rippleN_r;
	logic        rippleN_nxt;

	// Terminal decode: 15 going up, 0 going down
	function automatic logic isTerminal(input pudc_count_t cnt, input logic dir);
		isTerminal = (dir == PUDC_DIR_UP) ? (cnt == COUNT_MAX) : (cnt == COUNT_MIN);
	endfunction

	// Pack pins for the synchroniser
	always_comb begin
		rawS.countClk        = countClk;
		rawS.countEnableLow  = countEnableLow;
		rawS.directionSelect = directionSelect;
		rawS.loadN           = loadN;
		rawS.presetData      = presetData;
	end
	assign pinBus.rawPins = rawS;
	assign syncS          = pudc_pins_s'(pinBus.syncPins);

	pudc_pin_sync u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pins  (pinBus.syn)
	);

	// Count-clock rising edge, seen on synchronised level only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clkPrev_r <= 1'b0;
		end else begin
			clkPrev_r <= syncS.countClk;
		end
	end
	assign countEdge = syncS.countClk & ~clkPrev_r;

	// Next count: load first, then enabled edge, else hold
	always_comb begin
		count_nxt = count_r;
		if (!syncS.loadN) begin
			count_nxt = syncS.presetData;
		end else if (countEdge && !syncS.countEnableLow) begin
			if (syncS.directionSelect == PUDC_DIR_UP) begin
				count_nxt = count_r + STEP;
			end else begin
				count_nxt = count_r - STEP;
			end
		end
	end

	// All four bits in one register on one clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_r <= COUNT_RST;
		end else begin
			count_r <= count_nxt;
		end
	end

	// Cascade outputs follow the next count
	assign termFlag_nxt = isTerminal(count_nxt, syncS.directionSelect);
	assign rippleN_nxt  = ~(termFlag_nxt & ~syncS.countClk);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			termFlag_r <= 1'b0;
			rippleN_r  <= 1'b1;
		end else begin
			termFlag_r <= termFlag_nxt;
			rippleN_r  <= rippleN_nxt;
		end
	end

	assign countValue        = count_r;
	assign terminalCountFlag = termFlag_r;
	assign rippleClockOutN   = rippleN_r;

	// Checks on counting, load and cascade outputs
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_one_step;
		syncS.loadN && $past(syncS.loadN) |->
			(count_r == $past(count_r)) || (count_r == pudc_count_t'($past(count_r) + STEP))
			|| (count_r == pudc_count_t'($past(count_r) - STEP));
	endproperty
	a_one_step: assert property (p_one_step) else $error("count jumped by more than one");

	property p_hold_disabled;
		syncS.loadN && syncS.countEnableLow |=> count_r == $past(count_r);
	endproperty
	a_hold_disabled: assert property (p_hold_disabled) else $error("count moved while disabled");

	property p_count_up;
		syncS.loadN && countEdge && !syncS.countEnableLow && syncS.directionSelect == PUDC_DIR_UP
			|=> count_r == pudc_count_t'($past(count_r) + STEP);
	endproperty
	a_count_up: assert property (p_count_up) else $error("up count missed");

	property p_no_edge_hold;
		syncS.loadN && !countEdge |=> $stable(count_r);
	endproperty
	a_no_edge_hold: assert property (p_no_edge_hold) else $error("count moved between edges");

	property p_load;
		!syncS.loadN |=> count_r == $past(syncS.presetData);
	endproperty
	a_load: assert property (p_load) else $error("preset not taken");

	property p_load_beats_edge;
		!syncS.loadN && countEdge && !syncS.countEnableLow ##1 !syncS.loadN
			|-> count_r == $past(syncS.presetData);
	endproperty
	a_load_beats_edge: assert property (p_load_beats_edge) else $error("edge overrode load");

	property p_term_flag;
		terminalCountFlag |->
			(countValue == COUNT_MAX && $past(syncS.directionSelect) == PUDC_DIR_UP)
			|| (countValue == COUNT_MIN && $past(syncS.directionSelect) == PUDC_DIR_DOWN);
	endproperty
	a_term_flag: assert property (p_term_flag) else $error("terminal flag without terminal count");

	property p_ripple_low;
		!rippleClockOutN |-> terminalCountFlag && !$past(syncS.countClk);
	endproperty
	a_ripple_low: assert property (p_ripple_low) else $error("ripple low outside low clock phase");

	property p_ripple_follow;
		terminalCountFlag && !$past(syncS.countClk) |-> !rippleClockOutN;
	endproperty
	a_ripple_follow: assert property (p_ripple_follow) else $error("ripple missed terminal count");

	property p_wrap_up;
		count_r == COUNT_MAX && syncS.loadN && countEdge && !syncS.countEnableLow
			&& syncS.directionSelect == PUDC_DIR_UP |=> count_r == COUNT_MIN;
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("no wrap from 15 to 0");

	property p_wrap_down;
		count_r == COUNT_MIN && syncS.loadN && countEdge && !syncS.countEnableLow
			&& syncS.directionSelect == PUDC_DIR_DOWN |=> count_r == COUNT_MAX;
	endproperty
	a_wrap_down: assert property (p_wrap_down) else $error("no wrap from 0 to 15");

	// Main scenarios
	c_wrap_up: cover property (count_r == COUNT_MAX ##1 count_r == COUNT_MIN);
	c_wrap_down: cover property (count_r == COUNT_MIN ##1 count_r == COUNT_MAX);
	c_load: cover property (!syncS.loadN ##1 syncS.loadN);
	c_ripple: cover property (!rippleClockOutN);

endmodule // pudc_counter
`default_nettype wire

// ===== verification/pudc_next_stage.sv
// Model of the next cascaded counter stage
`timescale 1ns/100ps
`default_nettype none
module pudc_next_stage (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Cascade link
	input  wire logic       countClk,
	input  wire logic       directionSelect,
	input  wire logic       rippleClockOutN,
	// Upper count
	output var  logic [3:0] upperCount
);
	logic clkPrev_r;

	// Step in the shared direction on a shared count clock rise while the ripple enable is low
	always_ff @(posedge clk) begin
		clkPrev_r <= countClk;
		if (!rst_n) begin
			upperCount <= 4'h0;
		end else if (countClk && !clkPrev_r && !rippleClockOutN) begin
			upperCount <= directionSelect ? upperCount - 4'h1 : upperCount + 4'h1;
		end
	end
endmodule // pudc_next_stage
`default_nettype wire

// ===== verification/tb.sv
// Self-checking testbench of the up/down counter
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pudc_pkg::*;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        countClk = 1'h0;
	logic        countEnableLow = 1'h1;
	logic        directionSelect = 1'h0;
	logic        loadN = 1'h1;
	pudc_count_t presetData = 4'h0;
	pudc_count_t countValue;
	logic        terminalCountFlag;
	logic        rippleClockOutN;
	logic [3:0]  upperCount;
	pudc_count_t expCount = 4'h0;
	int          n_fail = 0;
	int          n_checks = 0;

	// 250 MHz clock
	always #2 clk = ~clk;

	pudc_counter uut (
		.clk(clk), .rst_n(rst_n), .countClk(countClk), .countEnableLow(countEnableLow),
		.directionSelect(directionSelect), .loadN(loadN), .presetData(presetData),
		.countValue(countValue), .terminalCountFlag(terminalCountFlag), .rippleClockOutN(rippleClockOutN)
	);
	pudc_next_stage nxt (
		.clk(clk), .rst_n(rst_n), .countClk(countClk), .directionSelect(directionSelect),
		.rippleClockOutN(rippleClockOutN), .upperCount(upperCount)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Compare a count
	task automatic chkCount(input pudc_count_t got, input pudc_count_t exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Compare a flag
	task automatic chkBit(input logic got, input logic exp);
		chkCount({3'h0, got}, {3'h0, exp});
	endtask

	// Terminal state expected from the count and direction
	function automatic logic isTerm();
		return (expCount == 4'hF && !directionSelect) || (expCount == 4'h0 && directionSelect);
	endfunction

	// One count clock period: low phase, then rise
	task automatic step(input logic moves);
		countClk <= 1'h0;
		cyc(5);
		if (moves) chkBit(rippleClockOutN, !isTerm());
		countClk <= 1'h1;
		if (moves) expCount = directionSelect ? expCount - 4'h1 : expCount + 4'h1;
		cyc(5);
		chkCount(countValue, expCount);
		chkBit(terminalCountFlag, isTerm());
		chkBit(rippleClockOutN, 1'h1);
	endtask

	// Main sequence
	initial begin
		cyc(12);
		rst_n <= 1'h1;
		cyc(2);
		chkCount(countValue, 4'h0);
		chkBit(terminalCountFlag, 1'h0);
		chkBit(rippleClockOutN, 1'h1);
		// Preset to 13
		loadN <= 1'h0;
		presetData <= 4'hD;
		cyc(5);
		expCount = 4'hD;
		chkCount(countValue, expCount);
		loadN <= 1'h1;
		countEnableLow <= 1'h0;
		cyc(3);
		repeat (5) step(1'h1);
		chkCount(upperCount, 4'h1);
		// Control changes without a count clock rise
		countEnableLow <= 1'h1;
		directionSelect <= 1'h1;
		cyc(4);
		countEnableLow <= 1'h0;
		cyc(4);
		chkCount(countValue, expCount);
		countEnableLow <= 1'h1;
		repeat (2) step(1'h0);
		countEnableLow <= 1'h0;
		cyc(3);
		repeat (5) step(1'h1);
		// Load held low while clocking
		loadN <= 1'h0;
		presetData <= 4'h5;
		expCount = 4'h5;
		repeat (2) step(1'h0);
		// Each of the six cycles after an enabled rise under load must show the preset
		countClk <= 1'h0;
		cyc(5);
		countClk <= 1'h1;
		repeat (6) begin
			cyc(1);
			chkCount(countValue, expCount);
		end
		chkCount(upperCount, 4'h0);
		wrap_up();
	end

	// Watchdog
	initial begin
		#20000;
		n_fail++;
		wrap_up();
	end
endmodule // tb
`default_nettype wire
